// *** logic/astg_gate.v ***
// Purpose: Acquisition start trigger gate for frame acquisition.
// Assumes: Host settings are static while a burst runs; inputs synchronous.
// Notes:   Frame start triggers pass only while the gate is open.
//
// Overview of operation
// - Reset loads idle; with gating enabled the block moves to the waiting-for-acquisition-start state once acquisition is active.
// - While waiting, frame start triggers are ignored and no frame is allowed.
// - A software acquisition start trigger moves the block to accepting frame triggers.
// - Accepted frame triggers are counted and the block re-arms when the count hits the burst size.
// - Each host trigger command gives one software start event while the acquisition start target and the software source are selected.
// - With the line source selected the start trigger is taken from input line 1.
// - The polarity setting picks rising or falling edge as the trigger.
// - After re-arming, each new qualifying line edge opens the gate again.
// - The burst size is only valid from 1 to 255.
// - With gating disabled frames are permitted as soon as acquisition is active and no start trigger is needed.
`timescale 1ns/1ps
`include "astg_defs.vh"

module astg_gate #(
  parameter FPB_WIDTH = `ASTG_FPB_WIDTH
) (
  input  wire                 clock,
  input  wire                 reset_n,
  input  wire                 trigger_gate_enable,
  input  wire                 trigger_origin_select,
  input  wire                 trigger_edge_polarity,
  input  wire                 trigger_target_select,
  input  wire                 capture_run_style,
  input  wire [FPB_WIDTH-1:0] frames_per_burst,
  input  wire                 acquisition_active,
  input  wire                 trigger_command,
  input  wire                 line1_in,
  input  wire                 frame_trigger_accepted,
  output reg                  frame_trigger_permitted,
  output reg                  waiting_for_start,
  output reg  [FPB_WIDTH-1:0] frames_taken,
  output reg                  start_event_seen,
  output reg                  setting_error
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [1:0] ST_IDLE     = 2'h0;
  localparam [1:0] ST_WAIT_ACQ = 2'h1;
  localparam [1:0] ST_FRAMES   = 2'h2;

  // Burst count constants at the configured width
  localparam [FPB_WIDTH-1:0] ZERO_FPB = {FPB_WIDTH{1'b0}};
  localparam [FPB_WIDTH-1:0] ONE_FPB  = {{(FPB_WIDTH-1){1'b0}}, 1'b1};

  reg  [1:0]           state_q;
  reg  [1:0]           state_d;
  reg  [FPB_WIDTH-1:0] count_q;
  reg  [FPB_WIDTH-1:0] count_d;
  reg                  cmd_prev_q;
  wire                 line_pulse;
  wire                 sw_start;
  wire                 hw_start;
  wire                 start_evt;
  wire                 last_frame;
  wire [FPB_WIDTH-1:0] burst_len;
  // Decoded host settings
  wire                 target_is_acq;
  wire                 origin_is_sw;
  wire                 origin_is_line;
  wire                 gate_live;
  wire                 open_evt;
  wire                 cfg_bad;

  // Clamp to the legal range so a zero never locks the gate open
  function [FPB_WIDTH-1:0] clamp_fpb;
    input [FPB_WIDTH-1:0] v;
    begin
      if (v == ZERO_FPB) begin
        clamp_fpb = ONE_FPB;
      end else begin
        clamp_fpb = v;
      end
    end
  endfunction

  // Count step; wraps at the field width, the burst end compare stops it first
  function [FPB_WIDTH-1:0] inc_fpb;
    input [FPB_WIDTH-1:0] v;
    begin
      inc_fpb = v + ONE_FPB;
    end
  endfunction

  // Line 1 synchroniser and edge select
  astg_edge_detect u_edge (
    .clock                    (clock),
    .reset_n                  (reset_n),
    .line_in                  (line1_in),
    .trigger_edge_polarity    (trigger_edge_polarity),
    .external_acq_start_pulse (line_pulse)
  );

  assign burst_len      = clamp_fpb(frames_per_burst);
  assign target_is_acq  = (trigger_target_select == `ASTG_TARGET_ACQ_START);
  assign origin_is_sw   = (trigger_origin_select == `ASTG_ORIGIN_SOFTWARE);
  assign origin_is_line = (trigger_origin_select == `ASTG_ORIGIN_LINE1);
  assign gate_live      = acquisition_active & trigger_gate_enable;
  // Command edge so a held level gives one event
  assign sw_start       = trigger_command & ~cmd_prev_q &
                          target_is_acq & origin_is_sw;
  assign hw_start       = line_pulse & origin_is_line;
  assign start_evt      = sw_start | hw_start;
  assign last_frame     = (inc_fpb(count_q) == burst_len);
  // Only an event that really opens the gate is reported
  assign open_evt       = (state_q == ST_WAIT_ACQ) & gate_live & start_evt;
  // Wrong run style or a zero burst size is host misconfiguration
  assign cfg_bad        = trigger_gate_enable &
                          ((capture_run_style != `ASTG_RUN_CONTINUOUS) |
                           (frames_per_burst == ZERO_FPB));

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    count_d = count_q;
    // Stopping acquisition from any state parks the gate in idle
    case (state_q)
      ST_IDLE: begin
        count_d = {FPB_WIDTH{1'b0}};
        if (acquisition_active && trigger_gate_enable)
          state_d = ST_WAIT_ACQ;
        else if (acquisition_active)
          state_d = ST_FRAMES;
      end
      ST_WAIT_ACQ: begin
        // Start events seen in other states are refused
        count_d = {FPB_WIDTH{1'b0}};
        if (!acquisition_active)
          state_d = ST_IDLE;
        else if (!trigger_gate_enable)
          state_d = ST_FRAMES;
        else if (start_evt)
          state_d = ST_FRAMES;
      end
      ST_FRAMES: begin
        if (!acquisition_active) begin
          state_d = ST_IDLE;
        end else if (!trigger_gate_enable) begin
          // Gate off: frames stay permitted, count parked
          count_d = {FPB_WIDTH{1'b0}};
        end else if (frame_trigger_accepted) begin
          if (last_frame) begin
            count_d = {FPB_WIDTH{1'b0}};
            state_d = ST_WAIT_ACQ;
          end else begin
            count_d = inc_fpb(count_q);
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
        count_d = {FPB_WIDTH{1'b0}};
      end
    endcase
  end

  // ----------------------------------------
  // State and burst count
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      state_q    <= ST_IDLE;
      count_q    <= ZERO_FPB;
      cmd_prev_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      count_q    <= count_d;
      cmd_prev_q <= trigger_command;
    end
  end

  // ----------------------------------------
  // Gate status outputs
  // ----------------------------------------
  // Taken from the next state so the ports move with the state register
  always @(posedge clock) begin
    if (!reset_n) begin
      frame_trigger_permitted <= 1'b0;
      waiting_for_start       <= 1'b0;
      frames_taken            <= ZERO_FPB;
    end else begin
      frame_trigger_permitted <= (state_d == ST_FRAMES);
      waiting_for_start       <= (state_d == ST_WAIT_ACQ);
      frames_taken            <= count_d;
    end
  end

  // ----------------------------------------
  // Start event pulse
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      start_event_seen <= 1'b0;
    end else begin
      start_event_seen <= open_evt;
    end
  end

  // ----------------------------------------
  // Host setting check
  // ----------------------------------------
  // Flags host misconfiguration only; the gate keeps running regardless
  always @(posedge clock) begin
    if (!reset_n) begin
      setting_error <= 1'b0;
    end else begin
      setting_error <= cfg_bad;
    end
  end

endmodule // astg_gate

// *** logic/astg_defs.vh ***
// Purpose: Constants for the acquisition start trigger gate.
// Assumes: Included by bare name from logic/ files.
// Notes:   Definitions only.
`ifndef ASTG_DEFS_VH
`define ASTG_DEFS_VH

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define ASTG_ORIGIN_SOFTWARE  1'h0
`define ASTG_ORIGIN_LINE1     1'h1
`define ASTG_EDGE_RISING      1'h0
`define ASTG_EDGE_FALLING     1'h1
`define ASTG_TARGET_FRAME     1'h0
`define ASTG_TARGET_ACQ_START 1'h1
`define ASTG_RUN_SINGLE       1'h0
`define ASTG_RUN_CONTINUOUS   1'h1

// ----------------------------------------
// Frame count limits and reset values
// ----------------------------------------
`define ASTG_FPB_WIDTH        8
`define ASTG_FPB_MIN          8'h01
`define ASTG_FPB_MAX          8'hFF
`define ASTG_FPB_RESET        8'h01

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ASTG_SYNC_WARMUP      2'h3

`endif

// *** logic/astg_edge_detect.v ***
// Purpose: Synchronise trigger line 1 and detect the selected edge.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Pulse is one clock wide, three cycles after the pin change.
`timescale 1ns/1ps
`include "astg_defs.vh"

module astg_edge_detect (
  input  wire clock,
  input  wire reset_n,
  input  wire line_in,
  input  wire trigger_edge_polarity,
  output reg  external_acq_start_pulse
);

  reg       sync1_q;
  reg       sync2_q;
  reg       prev_q;
  reg [1:0] warm_q;
  wire      rise;
  wire      fall;
  wire      warm;

  // Stage 1 feeds only stage 2 to settle metastability
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  // Edges stay masked until the pipeline holds real pin samples
  assign warm = (warm_q == `ASTG_SYNC_WARMUP);

  // ----------------------------------------
  // Synchroniser and edge pulse
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      sync1_q                  <= 1'b0;
      sync2_q                  <= 1'b0;
      prev_q                   <= 1'b0;
      warm_q                   <= 2'h0;
      external_acq_start_pulse <= 1'b0;
    end else begin
      sync1_q <= line_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      if (!warm) begin
        warm_q <= warm_q + 2'h1;
      end
      external_acq_start_pulse <= warm & ((trigger_edge_polarity == `ASTG_EDGE_FALLING) ?
                                          fall : rise);
    end
  end

endmodule // astg_edge_detect

// *** verification/astg_gate_asserts.sv ***
// Purpose: Concurrent checks on the acquisition start trigger gate ports.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   Line edge answer allowed 3 to 5 cycles for synchroniser latency.
`timescale 1ns/1ps
module astg_gate_asserts #(parameter FPB_WIDTH = 8) (
  input wire                 clock,
  input wire                 reset_n,
  input wire                 trigger_gate_enable,
  input wire                 trigger_origin_select,
  input wire                 trigger_edge_polarity,
  input wire                 trigger_target_select,
  input wire                 capture_run_style,
  input wire [FPB_WIDTH-1:0] frames_per_burst,
  input wire                 acquisition_active,
  input wire                 trigger_command,
  input wire                 line1_in,
  input wire                 frame_trigger_accepted,
  input wire                 frame_trigger_permitted,
  input wire                 waiting_for_start,
  input wire [FPB_WIDTH-1:0] frames_taken,
  input wire                 start_event_seen,
  input wire                 setting_error
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire live    = acquisition_active && trigger_gate_enable;
  wire sw_ok   = live && waiting_for_start && trigger_target_select && !trigger_origin_select;
  wire sw_bad  = waiting_for_start && !trigger_target_select && !trigger_origin_select;
  wire fr_ok   = frame_trigger_permitted && frame_trigger_accepted && trigger_gate_enable;
  // Clamp of a zero count falls out of the >= compare
  wire fr_end  = frames_taken + 1'b1 >= frames_per_burst;
  wire ln_ok   = live && waiting_for_start && trigger_origin_select &&
                 line1_in != trigger_edge_polarity;
  wire opened  = frame_trigger_permitted && start_event_seen;
  wire rearmed = waiting_for_start && frames_taken == 0;
  wire gate_off = !trigger_gate_enable && acquisition_active;

  a_wait_no_frame: assert property (waiting_for_start |-> !frame_trigger_permitted)
    else $error("frame permitted while waiting");
  a_sw_opens: assert property (sw_ok && $rose(trigger_command) |=> opened)
    else $error("software start did not open gate");
  a_sw_target: assert property (sw_bad && $rose(trigger_command) |=> !start_event_seen)
    else $error("command with frame target opened gate");
  a_last_rearm: assert property (fr_ok && fr_end |=> rearmed)
    else $error("gate did not re-arm at burst end");
  a_count_step: assert property (fr_ok && !fr_end |=>
    frames_taken == $past(frames_taken) + 1'b1)
    else $error("frame count did not step");
  a_line_opens: assert property (ln_ok && $changed(line1_in) |->
    ##[3:5] start_event_seen)
    else $error("line edge did not open gate");
  a_event_single: assert property (start_event_seen |=> !start_event_seen)
    else $error("start event longer than one cycle");
  a_gate_free: assert property (gate_off[*3] |-> frame_trigger_permitted)
    else $error("gate off but frames not permitted");
  c_sw: cover property (sw_ok && $rose(trigger_command));
  c_end: cover property (fr_ok && fr_end);
  c_line: cover property (start_event_seen && trigger_origin_select);
  c_free: cover property (gate_off[*3]);
endmodule // astg_gate_asserts
bind astg_gate astg_gate_asserts #(.FPB_WIDTH(FPB_WIDTH)) u_astg_chk (.*);

// *** verification/astg_line_src.sv ***
// Purpose: External trigger source driving input line 1.
// Assumes: line_fire is a one-cycle request from the bench.
// Notes:   Idle level equals polarity, so leaving idle is the qualifying edge.
`timescale 1ns/1ps
module astg_line_src (
  input  wire clock,
  input  wire trigger_edge_polarity,
  input  wire line_fire,
  output reg  line1_in
);
  reg [2:0] hold_q = 3'h0;
  // Held 4 cycles so the synchroniser cannot miss it
  always @(posedge clock) begin
    if (line_fire) hold_q <= 3'h4;
    else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
  end
  always @* line1_in = (hold_q != 3'h0) ? ~trigger_edge_polarity : trigger_edge_polarity;
endmodule // astg_line_src

// *** verification/testbench.sv ***
// Purpose: Self-checking bench for the acquisition start trigger gate.
// Assumes: Inputs change 2 ns after the rising edge.
// Notes:   Burst sizes are random with 255 and 0 as corner cases.
`timescale 1ns/1ps
module testbench;
  logic       clock = 0, reset_n = 0, trigger_gate_enable = 1, trigger_origin_select = 0;
  logic       trigger_edge_polarity = 0, trigger_target_select = 1, capture_run_style = 1;
  logic       acquisition_active = 1, trigger_command = 0, frame_trigger_accepted = 0;
  logic       line_fire = 0;
  logic [7:0] frames_per_burst = 8'h02;
  wire        line1_in, frame_trigger_permitted, waiting_for_start, start_event_seen;
  wire        setting_error;
  wire  [7:0] frames_taken;
  integer     failures = 0, n_compared = 0, seed = 32'had3e, k, i, n;
  astg_gate dut (.*);
  astg_line_src u_src (.*);
  initial forever #25 clock = ~clock;
  task step(input integer c); repeat (c) @(posedge clock); #2; endtask
  task chk(input [8*6:1] nm, input [7:0] e, input [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0s expected %0h seen %0h", nm, e, g);
    end
  endtask
  function [7:0] exp_fpb(input [7:0] v); exp_fpb = (v == 8'h00) ? 8'h01 : v; endfunction
  task final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task wait_open;
    for (i = 0; i < 10 && frame_trigger_permitted !== 1'b1; i++) step(1);
    if (frame_trigger_permitted !== 1'b1) begin
      failures++;
      $display("MISMATCH permitted expected 1 seen %b", frame_trigger_permitted);
      final_report;
    end
    chk("event", 8'h01, start_event_seen);
  endtask
  task burst(input [7:0] m);
    for (n = 1; n <= m; n++) begin
      frame_trigger_accepted = 1;
      step(1);
      frame_trigger_accepted = 0;
      chk("taken", (n == m) ? 8'h00 : n, frames_taken);
      chk("wait", n == m, waiting_for_start);
      step(1);
    end
  endtask
  initial begin
    step(12);
    reset_n = 1;
    step(2);
    chk("wait", 8'h01, waiting_for_start);
    frame_trigger_accepted = 1;
    step(1);
    frame_trigger_accepted = 0;
    step(1);
    chk("perm", 8'h00, frame_trigger_permitted);
    chk("taken", 8'h00, frames_taken);
    trigger_target_select = 0;
    trigger_command = 1;
    step(2);
    trigger_command = 0;
    trigger_target_select = 1;
    step(1);
    chk("wait", 8'h01, waiting_for_start);
    capture_run_style = 0;
    step(2);
    chk("error", 8'h01, setting_error);
    capture_run_style = 1;
    for (k = 0; k < 6; k++) begin
      trigger_origin_select = k > 1;
      trigger_edge_polarity = k[0];
      frames_per_burst = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : ($random(seed) & 7) + 1;
      step(6);
      chk("error", k == 1, setting_error);
      if (k < 2) trigger_command = 1;
      else line_fire = 1;
      step(1);
      trigger_command = 0;
      line_fire = 0;
      wait_open;
      burst(exp_fpb(frames_per_burst));
    end
    acquisition_active = 0;
    step(2);
    chk("wait", 8'h00, waiting_for_start);
    trigger_gate_enable = 0;
    acquisition_active = 1;
    step(3);
    chk("perm", 8'h01, frame_trigger_permitted);
    final_report;
  end
endmodule // testbench
